/* include/gpio_abc_pkg.sv */
package gpio_abc_pkg;

    // ==========================================================
    // widths
    localparam int unsigned PA_W    = 6;
    localparam int unsigned PB_W    = 8;
    localparam int unsigned PC_W    = 4;
    localparam int unsigned REG_W   = 8;
    localparam int unsigned WB_DW   = 32;
    localparam int unsigned WB_AW   = 8;

    // ==========================================================
    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_PA_DATA = 4'h0;
    localparam logic [3:0] IDX_PB_DATA = 4'h1;
    localparam logic [3:0] IDX_PC_DATA = 4'h2;
    localparam logic [3:0] IDX_PA_DIR  = 4'h4;
    localparam logic [3:0] IDX_PB_DIR  = 4'h5;
    localparam logic [3:0] IDX_PC_DIR  = 4'h6;
    localparam logic [3:0] IDX_PA_PUE  = 4'h8;
    localparam logic [3:0] IDX_PB_PUE  = 4'h9;

    // ==========================================================
    // field positions and masks
    localparam int unsigned PA_IN_ONLY_BIT = 2;
    localparam int unsigned PA_CLK_PIN_BIT = 4;
    localparam int unsigned OSC_SEL_BIT    = 7;
    localparam int unsigned PC_IN_ONLY_BIT = 3;
    localparam logic [PA_W-1:0] PA_WR_MASK = 6'h3b;
    localparam logic [2:0]      PC_WR_MASK = 3'h7;

    // ==========================================================
    // reset values
    localparam logic [REG_W-1:0] DIR_RST = 8'h00;
    localparam logic [REG_W-1:0] PUE_RST = 8'h00;

endpackage : gpio_abc_pkg

/* hw/port_pin_slice.sv */
`timescale 1ns/1ps
module port_pin_slice
    import gpio_abc_pkg::*;
#(
    parameter int unsigned W = 8
)
(
    input  wire logic [W-1:0] dir_i,
    input  wire logic [W-1:0] latch_i,
    input  wire logic [W-1:0] pue_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] rd_o,
    output logic      [W-1:0] pullup_o
);

    // ==========================================================
    // read mux and pullup gating per pin
    // driven pins read back the latch, inputs read the live level
    assign rd_o     = (dir_i & latch_i) | (~dir_i & pin_i);
    // pullup is cut the moment a pin turns output, whatever its enable
    assign pullup_o = pue_i & ~dir_i;

endmodule : port_pin_slice

/* hw/gpio_ports_abc_pullup.sv */
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
module gpio_ports_abc_pullup
    import gpio_abc_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // classic wishbone slave
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    input  wire logic             we_i,
    input  wire logic [WB_AW-1:0] adr_i,
    input  wire logic [3:0]       sel_i,
    input  wire logic [WB_DW-1:0] dat_i,
    output logic      [WB_DW-1:0] dat_o,
    output logic                  ack_o,
    // oscillator context
    input  wire logic             osc_internal_i,
    input  wire logic             quad_bus_clock_i,
    // port a pins
    input  wire logic [PA_W-1:0]  port_a_in_i,
    output logic      [PA_W-1:0]  port_a_out_o,
    output logic      [PA_W-1:0]  port_a_oe_o,
    output logic      [PA_W-1:0]  port_a_pullup_o,
    // port b pins
    input  wire logic [PB_W-1:0]  port_b_in_i,
    output logic      [PB_W-1:0]  port_b_out_o,
    output logic      [PB_W-1:0]  port_b_oe_o,
    output logic      [PB_W-1:0]  port_b_pullup_o,
    // port c pins
    input  wire logic [PC_W-1:0]  port_c_in_i,
    output logic      [PC_W-1:0]  port_c_out_o,
    output logic      [PC_W-1:0]  port_c_oe_o
);

    // ==========================================================
    // storage
    logic [PA_W-1:0]  port_a_data_ff;
    logic [PB_W-1:0]  port_b_data_ff;
    logic [2:0]       port_c_data_ff;
    logic [PA_W-1:0]  port_a_direction_ff;
    logic [PB_W-1:0]  port_b_direction_ff;
    logic [2:0]       port_c_direction_ff;
    logic [PA_W-1:0]  port_a_pullup_enable_ff;
    logic             osc_pin_clock_out_select_ff;
    logic [PB_W-1:0]  port_b_pullup_enable_ff;
    logic             ack_ff;
    logic [WB_DW-1:0] dat_ff;

    // ==========================================================
    // bus decode
    logic [3:0]       reg_idx;
    logic             adr_ok;
    logic             req;
    logic             wr_lane0;
    logic             hit_pa_data;
    logic             hit_pb_data;
    logic             hit_pc_data;
    logic             hit_pa_dir;
    logic             hit_pb_dir;
    logic             hit_pc_dir;
    logic             hit_pa_pue;
    logic             hit_pb_pue;
    logic [REG_W-1:0] wr_byte;

    // word-aligned decode; upper address bits must be zero
    assign reg_idx     = adr_i[5:2];
    assign adr_ok      = (adr_i[WB_AW-1:6] == 2'h0);
    assign req         = cyc_i & stb_i;
    // writes land on the edge where ack is seen, lane 0 only
    assign wr_lane0    = req & we_i & ack_ff & sel_i[0];
    assign wr_byte     = dat_i[REG_W-1:0];
    assign hit_pa_data = wr_lane0 & adr_ok & (reg_idx == IDX_PA_DATA);
    assign hit_pb_data = wr_lane0 & adr_ok & (reg_idx == IDX_PB_DATA);
    assign hit_pc_data = wr_lane0 & adr_ok & (reg_idx == IDX_PC_DATA);
    assign hit_pa_dir  = wr_lane0 & adr_ok & (reg_idx == IDX_PA_DIR);
    assign hit_pb_dir  = wr_lane0 & adr_ok & (reg_idx == IDX_PB_DIR);
    assign hit_pc_dir  = wr_lane0 & adr_ok & (reg_idx == IDX_PC_DIR);
    assign hit_pa_pue  = wr_lane0 & adr_ok & (reg_idx == IDX_PA_PUE);
    assign hit_pb_pue  = wr_lane0 & adr_ok & (reg_idx == IDX_PB_PUE);

    // ==========================================================
    // effective pin configuration
    logic             clk_out_on;
    logic [PA_W-1:0]  pa_dir_eff;
    logic [PA_W-1:0]  pa_pue_eff;
    logic [PA_W-1:0]  pa_rd;
    logic [PA_W-1:0]  pa_pull;
    logic [PB_W-1:0]  pb_rd;
    logic [PC_W-1:0]  pc_dir_eff;
    logic [PC_W-1:0]  pc_latch;
    logic [PC_W-1:0]  pc_rd;
    logic [PC_W-1:0]  pc_pull_unused;

    // the select only counts while the internal or rc source runs
    assign clk_out_on = osc_pin_clock_out_select_ff & osc_internal_i;
    // clock-out mode takes the pin away from general i/o and its pullup
    assign pa_dir_eff = port_a_direction_ff
                      | (clk_out_on ? 6'h10 : 6'h00);
    assign pa_pue_eff = port_a_pullup_enable_ff
                      & (clk_out_on ? 6'h2f : 6'h3f);
    // bit 3 of port c never drives
    assign pc_dir_eff = {1'b0, port_c_direction_ff};
    assign pc_latch   = {1'b0, port_c_data_ff};

    port_pin_slice #(.W(PA_W)) u_port_a
    (
        .dir_i    (pa_dir_eff),
        .latch_i  (port_a_data_ff),
        .pue_i    (pa_pue_eff),
        .pin_i    (port_a_in_i),
        .rd_o     (pa_rd),
        .pullup_o (pa_pull)
    );

    port_pin_slice #(.W(PB_W)) u_port_b
    (
        .dir_i    (port_b_direction_ff),
        .latch_i  (port_b_data_ff),
        .pue_i    (port_b_pullup_enable_ff),
        .pin_i    (port_b_in_i),
        .rd_o     (pb_rd),
        .pullup_o (port_b_pullup_o)
    );

    // port c has no pullups; only the read mux is used here
    port_pin_slice #(.W(PC_W)) u_port_c
    (
        .dir_i    (pc_dir_eff),
        .latch_i  (pc_latch),
        .pue_i    (4'h0),
        .pin_i    (port_c_in_i),
        .rd_o     (pc_rd),
        .pullup_o (pc_pull_unused)
    );

    // ==========================================================
    // pin drive
    // the clock path is combinational: a flop would halve it
    assign port_a_out_o    = clk_out_on
                           ? ((port_a_data_ff & 6'h2f)
                             | {1'b0, quad_bus_clock_i, 4'h0})
                           : port_a_data_ff;
    assign port_a_oe_o     = pa_dir_eff;
    assign port_a_pullup_o = pa_pull;
    assign port_b_out_o    = port_b_data_ff;
    assign port_b_oe_o     = port_b_direction_ff;
    assign port_c_out_o    = pc_latch;
    assign port_c_oe_o     = pc_dir_eff;

    // ==========================================================
    // read data mux
    logic [REG_W-1:0] rd_byte;

    // unmapped offsets and unused bit positions read as zero
    assign rd_byte =
        !adr_ok                   ? 8'h00 :
        reg_idx == IDX_PA_DATA    ? {2'h0, pa_rd} :
        reg_idx == IDX_PB_DATA    ? pb_rd :
        reg_idx == IDX_PC_DATA    ? {4'h0, pc_rd} :
        reg_idx == IDX_PA_DIR     ? {2'h0, port_a_direction_ff} :
        reg_idx == IDX_PB_DIR     ? port_b_direction_ff :
        reg_idx == IDX_PC_DIR     ? {5'h00, port_c_direction_ff} :
        reg_idx == IDX_PA_PUE     ? {osc_pin_clock_out_select_ff, 1'b0,
                                     port_a_pullup_enable_ff} :
        reg_idx == IDX_PB_PUE     ? port_b_pullup_enable_ff :
                                    8'h00;

    // ==========================================================
    // bus handshake: ack one cycle after the strobe, then drop
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_ff <= 1'b0;
            dat_ff <= '0;
        end
        else
        begin
            ack_ff <= req & ~ack_ff;
            dat_ff <= {24'h000000, rd_byte};
        end
    end

    assign ack_o = ack_ff;
    assign dat_o = dat_ff;

    // ==========================================================
    // data latches: no reset, written whatever the direction
    always_ff @(posedge clk_i)
    begin
        if (hit_pa_data)
        begin
            // bit 2 is read-only and keeps its old value
            port_a_data_ff <= (wr_byte[PA_W-1:0] & PA_WR_MASK)
                            | (port_a_data_ff & ~PA_WR_MASK);
        end
        if (hit_pb_data)
        begin
            port_b_data_ff <= wr_byte;
        end
        if (hit_pc_data)
        begin
            port_c_data_ff <= wr_byte[2:0] & PC_WR_MASK;
        end
    end

    // ==========================================================
    // direction registers, cleared to all-input by reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            port_a_direction_ff <= DIR_RST[PA_W-1:0];
            port_b_direction_ff <= DIR_RST;
            port_c_direction_ff <= DIR_RST[2:0];
        end
        else
        begin
            if (hit_pa_dir)
            begin
                port_a_direction_ff <= wr_byte[PA_W-1:0] & PA_WR_MASK;
            end
            if (hit_pb_dir)
            begin
                port_b_direction_ff <= wr_byte;
            end
            if (hit_pc_dir)
            begin
                port_c_direction_ff <= wr_byte[2:0];
            end
        end
    end

    // ==========================================================
    // pullup enables and the clock-out select
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            port_a_pullup_enable_ff     <= PUE_RST[PA_W-1:0];
            osc_pin_clock_out_select_ff <= PUE_RST[OSC_SEL_BIT];
            port_b_pullup_enable_ff     <= PUE_RST;
        end
        else
        begin
            if (hit_pa_pue)
            begin
                port_a_pullup_enable_ff     <= wr_byte[PA_W-1:0];
                osc_pin_clock_out_select_ff <= wr_byte[OSC_SEL_BIT];
            end
            if (hit_pb_pue)
            begin
                port_b_pullup_enable_ff <= wr_byte;
            end
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // a write to one register, seen at its acknowledging edge
    sequence s_wr_pb_data;
        cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_ok
            && reg_idx == IDX_PB_DATA;
    endsequence

    sequence s_rd_pc_data;
        cyc_i && stb_i && !we_i && !ack_o && adr_ok
            && reg_idx == IDX_PC_DATA;
    endsequence

    sequence s_rd_pb_data;
        cyc_i && stb_i && !we_i && !ack_o && adr_ok
            && reg_idx == IDX_PB_DATA;
    endsequence

    property p_pullup_off_when_output;
        ((port_b_pullup_o & port_b_direction_ff) == 8'h00)
            && ((port_a_pullup_o & port_a_oe_o) == 6'h00);
    endproperty
    a_pullup_off_when_output: assert property (p_pullup_off_when_output)
        else $error("pullup left on for an output pin");

    property p_clock_on_pin;
        clk_out_on |-> port_a_oe_o[PA_CLK_PIN_BIT]
            && port_a_out_o[PA_CLK_PIN_BIT] == quad_bus_clock_i
            && !port_a_pullup_o[PA_CLK_PIN_BIT];
    endproperty
    a_clock_on_pin: assert property (p_clock_on_pin)
        else $error("quad bus clock not on oscillator output pin");

    property p_crystal_ignores_select;
        !osc_internal_i |-> port_a_oe_o[PA_CLK_PIN_BIT]
            == port_a_direction_ff[PA_CLK_PIN_BIT];
    endproperty
    a_crystal_ignores_select: assert property (p_crystal_ignores_select)
        else $error("clock-out select acted in crystal mode");

    property p_pa_pullup_gate;
        port_a_pullup_o == (port_a_pullup_enable_ff & ~pa_dir_eff);
    endproperty
    a_pa_pullup_gate: assert property (p_pa_pullup_gate)
        else $error("port a pullup wrong for enable and direction");

    property p_pb_write_updates_latch;
        s_wr_pb_data |=> port_b_out_o == $past(dat_i[7:0]);
    endproperty
    a_pb_write_updates_latch: assert property (p_pb_write_updates_latch)
        else $error("port b latch missed a write");

    // own disable: the default one would abort every attempt under reset
    property p_reset_dir_cleared;
        @(posedge clk_i) disable iff (1'b0)
            rst_i |=> port_b_oe_o == 8'h00 && port_c_oe_o == 4'h0;
    endproperty
    a_reset_dir_cleared: assert property (p_reset_dir_cleared)
        else $error("direction not cleared by reset");

    property p_pb_read_mix;
        s_rd_pb_data |=> ack_o && dat_o[7:0]
            == (($past(port_b_direction_ff) & $past(port_b_data_ff))
              | (~$past(port_b_direction_ff) & $past(port_b_in_i)));
    endproperty
    a_pb_read_mix: assert property (p_pb_read_mix)
        else $error("port b read returned wrong mix");

    property p_pc_read_mix;
        s_rd_pc_data |=> ack_o && dat_o[WB_DW-1:4] == 28'h0
            && dat_o[3] == $past(port_c_in_i[3]);
    endproperty
    a_pc_read_mix: assert property (p_pc_read_mix)
        else $error("port c read wrong or upper bits set");

    property p_input_only_pins;
        !port_c_oe_o[PC_IN_ONLY_BIT] && !port_a_oe_o[PA_IN_ONLY_BIT];
    endproperty
    a_input_only_pins: assert property (p_input_only_pins)
        else $error("input-only pin driven");

    property p_ack_one_cycle;
        ack_o |=> !ack_o;
    endproperty
    a_ack_one_cycle: assert property (p_ack_one_cycle)
        else $error("ack held longer than one cycle");

endmodule : gpio_ports_abc_pullup

/* test/pin_world_model.sv */
`timescale 1ns/1ps
// ==========================================================
// pins of one port: the device, outside drivers and pullups
module pin_world_model
#(
    parameter int unsigned W = 8
)
(
    input  wire logic         clk_i,
    input  wire logic [W-1:0] oe_i,
    input  wire logic [W-1:0] out_i,
    input  wire logic [W-1:0] pullup_i,
    input  wire logic [W-1:0] ext_en_i,
    input  wire logic [W-1:0] ext_i,
    output logic      [W-1:0] pin_o
);
    logic [W-1:0] float_ff = '0;

    // a floating pin wanders each cycle so a stale level never looks valid
    always_ff @(posedge clk_i)
    begin
        float_ff <= ~float_ff;
    end

    // device drive wins, then the outside driver, then the pullup
    assign pin_o = (oe_i & out_i)
                 | (~oe_i & ext_en_i & ext_i)
                 | (~oe_i & ~ext_en_i & pullup_i)
                 | (~oe_i & ~ext_en_i & ~pullup_i & float_ff);
endmodule : pin_world_model

/* test/gpio_ports_abc_pullup_bench.sv */
`timescale 1ns/1ps
module gpio_ports_abc_pullup_bench;
    import gpio_abc_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
    logic we_i = 1'b0, osc_internal_i = 1'b1, quad_bus_clock_i = 1'b0;
    logic [WB_AW-1:0] adr_i = '0;
    logic [3:0] sel_i = '0;
    logic [WB_DW-1:0] dat_i = '0, dat_o;
    logic ack_o;
    logic [PA_W-1:0] pa_in, pa_out, pa_oe, pa_pu, ext_en_a = '0, ext_a = '0;
    logic [PB_W-1:0] pb_in, pb_out, pb_oe, pb_pu, ext_en_b = '0, ext_b = '0;
    logic [PC_W-1:0] pc_in, pc_out, pc_oe, ext_en_c = '0, ext_c = '0;
    int n_fail = 0, total_checks = 0, cycles = 0;
    logic [31:0] bus_q;

    // ==========================================================
    // clock, quad clock source and hang guard
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) quad_bus_clock_i <= ~quad_bus_clock_i;
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_fail++;
            complete_run();
        end
    end

    // ==========================================================
    // design and the world around its pins
    gpio_ports_abc_pullup gpio_ports_abc_pullup_inst (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .osc_internal_i(osc_internal_i),
        .quad_bus_clock_i(quad_bus_clock_i),
        .port_a_in_i(pa_in), .port_a_out_o(pa_out), .port_a_oe_o(pa_oe),
        .port_a_pullup_o(pa_pu), .port_b_in_i(pb_in),
        .port_b_out_o(pb_out), .port_b_oe_o(pb_oe),
        .port_b_pullup_o(pb_pu), .port_c_in_i(pc_in),
        .port_c_out_o(pc_out), .port_c_oe_o(pc_oe));
    pin_world_model #(.W(PA_W)) pin_world_model_inst_a (.clk_i(clk_i),
        .oe_i(pa_oe), .out_i(pa_out), .pullup_i(pa_pu),
        .ext_en_i(ext_en_a), .ext_i(ext_a), .pin_o(pa_in));
    pin_world_model #(.W(PB_W)) pin_world_model_inst_b (.clk_i(clk_i),
        .oe_i(pb_oe), .out_i(pb_out), .pullup_i(pb_pu),
        .ext_en_i(ext_en_b), .ext_i(ext_b), .pin_o(pb_in));
    // port c has no pullups, so the model sees none
    pin_world_model #(.W(PC_W)) pin_world_model_inst_c (.clk_i(clk_i),
        .oe_i(pc_oe), .out_i(pc_out), .pullup_i(4'h0),
        .ext_en_i(ext_en_c), .ext_i(ext_c), .pin_o(pc_in));

    // ==========================================================
    // verdict, comparison and bus tasks
    task automatic complete_run();
        if (n_fail == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    function automatic logic [7:0] ra(input logic [3:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction : ra

    // one classic cycle; request held until the edge that samples ack
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d, input logic [3:0] s,
                       output logic [31:0] q);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= {24'h0, d};
        // no own limit: only the bench-wide cycle ceiling ends a hang
        do
            @(posedge clk_i);
        while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'h1, q);
    endtask : wr

    task automatic rd(input string name, input logic [7:0] a,
                      input logic [7:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, 4'h1, q);
        chk(name, {24'h0, exp}, q);
    endtask : rd

    // ==========================================================
    // scenarios
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("pb_dir", ra(IDX_PB_DIR), 8'h00);
        rd("pc_dir", ra(IDX_PC_DIR), 8'h00);
        rd("pb_pue", ra(IDX_PB_PUE), 8'h00);
        // port b: pullups, latch behind inputs, mixed directions
        wr(ra(IDX_PB_PUE), 8'hff);
        rd("pb_pulled", ra(IDX_PB_DATA), 8'hff);
        wr(ra(IDX_PB_DATA), 8'h3c);
        rd("pb_in_wr", ra(IDX_PB_DATA), 8'hff);
        wr(ra(IDX_PB_DIR), 8'h0f);
        @(negedge clk_i);
        chk("pb_oe", 32'h0f, 32'(pb_oe));
        chk("pb_pu_off", 32'hf0, 32'(pb_pu));
        chk("pb_out", 32'h3c, 32'(pb_out));
        rd("pb_mixed", ra(IDX_PB_DATA), 8'hfc);
        ext_en_b <= 8'hff;
        ext_b    <= 8'ha5;
        wr(ra(IDX_PB_PUE), 8'h00);
        @(negedge clk_i);
        chk("pb_pu_clr", 32'h00, 32'(pb_pu));
        rd("pb_driven", ra(IDX_PB_DATA), 8'hac);
        // latch survives a mid-run reset, direction does not
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk("pb_oe_rst", 32'h00, 32'(pb_oe));
        wr(ra(IDX_PB_DIR), 8'hff);
        rd("pb_latch", ra(IDX_PB_DATA), 8'h3c);
        bus(1'b1, ra(IDX_PB_DATA), 8'h00, 4'h0, bus_q);
        rd("pb_sel0", ra(IDX_PB_DATA), 8'h3c);
        // port c: three drivable bits and an input-only top bit
        ext_en_c <= 4'hf;
        ext_c    <= 4'h0;
        wr(ra(IDX_PC_DATA), 8'hff);
        wr(ra(IDX_PC_DIR), 8'hff);
        rd("pc_dir_rb", ra(IDX_PC_DIR), 8'h07);
        @(negedge clk_i);
        chk("pc_oe", 32'h7, 32'(pc_oe));
        chk("pc_out", 32'h7, 32'(pc_out));
        rd("pc_lo", ra(IDX_PC_DATA), 8'h07);
        ext_c <= 4'h8;
        rd("pc_hi", ra(IDX_PC_DATA), 8'h0f);
        wr(ra(IDX_PC_DIR), 8'h00);
        ext_c <= 4'h5;
        rd("pc_in", ra(IDX_PC_DATA), 8'h05);
        // port a: pullups and the clock-out select
        wr(ra(IDX_PA_PUE), 8'h7f);
        rd("pa_pue_rb", ra(IDX_PA_PUE), 8'h3f);
        @(negedge clk_i);
        chk("pa_pu", 32'h3f, 32'(pa_pu));
        wr(ra(IDX_PA_PUE), 8'hbf);
        repeat (2)
        begin
            @(negedge clk_i);
            chk("pa_oe_clk", 32'h10, 32'(pa_oe));
            chk("pa_pu_clk", 32'h2f, 32'(pa_pu));
            chk("pa_clk", 32'(quad_bus_clock_i), 32'(pa_out[4]));
        end
        @(posedge clk_i);
        osc_internal_i <= 1'b0;
        @(negedge clk_i);
        chk("pa_oe_crystal_option", 32'h00, 32'(pa_oe));
        chk("pa_pu_crystal_option", 32'h3f, 32'(pa_pu));
        @(posedge clk_i);
        osc_internal_i <= 1'b1;
        wr(ra(IDX_PA_PUE), 8'h3f);
        wr(ra(IDX_PA_DATA), 8'h00);
        wr(ra(IDX_PA_DIR), 8'h3f);
        @(negedge clk_i);
        // bit 2 never turns output, so its pullup stays on
        chk("pa_pu_out", 32'h04, 32'(pa_pu));
        chk("pa_oe", 32'h3b, 32'(pa_oe));
        chk("pa_out", 32'h00, 32'(pa_out & 6'h3b));
        @(posedge clk_i);
        ext_en_a <= 6'h3f;
        ext_a    <= 6'h3f;
        rd("pa_data", ra(IDX_PA_DATA), 8'h04);
        // unmapped place reads zero and swallows writes
        wr(8'h40, 8'h5a);
        rd("unmapped", 8'h40, 8'h00);
        // 0x40 would alias port a data if the upper bits were ignored
        rd("pa_kept", ra(IDX_PA_DATA), 8'h04);
        complete_run();
    end
endmodule : gpio_ports_abc_pullup_bench
